// ---- verilog/position_error_clear_gear.sv ----
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ns
module position_error_clear_gear #(
    parameter int ERR_W = pos_err_pkg::ERR_W
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // classic wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // reference and feedback pulses
    input wire logic refPulse,
    input wire logic refDir,
    input wire logic fbPulse,
    input wire logic fbDir,
    // drive status and clear pin
    input wire logic errorClearN,
    input wire logic servoOn,
    input wire logic overtravel,
    input wire logic zeroClampStop,
    // towards the position loop
    output logic loopEnable,
    output logic [ERR_W-1:0] posError,
    output logic inputNoiseFilterSel
);
    // ********************
    // state
    // ********************
    typedef struct packed {
        logic [ERR_W-1:0] err;
        logic [15:0] num;
        logic [15:0] den;
        logic [15:0] rem;
        logic [1:0] mode;
        logic width;
        logic filt;
        logic ack;
        logic [31:0] rdat;
        logic loopEn;
    } state_type;
    state_type st_r, st_nxt;

    logic [16:0] acc;
    logic [16:0] units;
    logic autoClr;
    logic [ERR_W-1:0] delta;
    logic [15:0] effNum;
    logic req;
    logic [31:0] ctrlRd;

    // ********************
    // next state
    // ********************
    always_comb begin
        st_nxt = st_r;
        req = cyc_i && stb_i && !st_r.ack;
        st_nxt.ack = req;

        // ********************
        // electronic gear
        // ********************
        // 16-bit gear in use only when selected; otherwise unity gearing
        effNum = st_r.width ? st_r.num : st_r.den;
        // reference unit scaled by num/den, remainder kept so no pulse is lost while num <= 2*den
        acc = {1'b0, st_r.rem};
        units = 17'h0;
        if (refPulse) begin
            acc = {1'b0, st_r.rem} + {1'b0, effNum};
            units = 17'h0;
            // two passes suffice only while num <= 2*den; larger ratios saturate at 2
            if (acc >= {1'b0, st_r.den}) begin
                acc = acc - {1'b0, st_r.den};
                units = 17'h1;
            end
            if (acc >= {1'b0, st_r.den}) begin
                acc = acc - {1'b0, st_r.den};
                units = 17'h2;
            end
        end
        st_nxt.rem = acc[15:0];
        delta = ERR_W'(units);

        // ********************
        // error counter
        // ********************
        // servo off does not stop accumulation by itself
        if (refDir) begin
            st_nxt.err = st_r.err + delta;
        end else begin
            st_nxt.err = st_r.err - delta;
        end
        if (fbPulse) begin
            if (fbDir) begin
                st_nxt.err = st_nxt.err - ERR_W'(1);
            end else begin
                st_nxt.err = st_nxt.err + ERR_W'(1);
            end
        end

        // ********************
        // automatic and pin clear
        // ********************
        unique case (st_r.mode)
            pos_err_pkg::MODE_CLR_SOFF: begin
                autoClr = !servoOn;
            end
            pos_err_pkg::MODE_NO_CLR: begin
                autoClr = 1'b0;
            end
            pos_err_pkg::MODE_CLR_SOFF_OT: begin
                autoClr = !servoOn || (overtravel && !zeroClampStop);
            end
            default: begin
                // the spare code behaves as no automatic clear
                autoClr = 1'b0;
            end
        endcase
        // a clear wins over pulses in the same cycle
        if (!errorClearN || autoClr) begin
            st_nxt.err = ERR_W'(pos_err_pkg::ERR_RESET);
            st_nxt.rem = pos_err_pkg::REM_RESET;
        end

        // ********************
        // position loop
        // ********************
        st_nxt.loopEn = errorClearN && servoOn;

        // ********************
        // register access
        // ********************
        // read-only servo state sits beside the writable fields
        ctrlRd = 32'h0;
        ctrlRd[pos_err_pkg::CTRL_MODE_LSB +: pos_err_pkg::MODE_W] = st_r.mode;
        ctrlRd[pos_err_pkg::CTRL_WIDTH_BIT] = st_r.width;
        ctrlRd[pos_err_pkg::CTRL_FILT_BIT] = st_r.filt;
        ctrlRd[pos_err_pkg::CTRL_SON_BIT] = servoOn;
        // a write takes effect at the edge that raises ack
        st_nxt.rdat = 32'h0;
        if (req) begin
            unique case (adr_i)
                pos_err_pkg::OFS_CTRL: begin
                    st_nxt.rdat = ctrlRd;
                    if (we_i && sel_i[0]) begin
                        st_nxt.mode = dat_i[pos_err_pkg::CTRL_MODE_LSB +: pos_err_pkg::MODE_W];
                        st_nxt.width = dat_i[pos_err_pkg::CTRL_WIDTH_BIT];
                        st_nxt.filt = dat_i[pos_err_pkg::CTRL_FILT_BIT];
                    end
                end
                pos_err_pkg::OFS_NUM: begin
                    st_nxt.rdat = {16'h0, st_r.num};
                    if (we_i && sel_i[0]) begin
                        st_nxt.num[7:0] = dat_i[7:0];
                    end
                    if (we_i && sel_i[1]) begin
                        st_nxt.num[15:8] = dat_i[15:8];
                    end
                end
                pos_err_pkg::OFS_DEN: begin
                    st_nxt.rdat = {16'h0, st_r.den};
                    if (we_i && sel_i[0]) begin
                        st_nxt.den[7:0] = dat_i[7:0];
                    end
                    if (we_i && sel_i[1]) begin
                        st_nxt.den[15:8] = dat_i[15:8];
                    end
                    if (we_i && sel_i[1:0] != 2'h0 && st_nxt.den == 16'h0) begin
                        // zero denominator would stall the remainder logic
                        st_nxt.den = pos_err_pkg::DEN_RESET;
                    end
                end
                pos_err_pkg::OFS_ERR: begin
                    st_nxt.rdat = 32'(st_r.err);
                end
                default: begin
                    // unmapped offsets read as zero and ignore writes
                    st_nxt.rdat = 32'h0;
                end
            endcase
        end
    end

    // ********************
    // registers
    // ********************
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_r.err <= ERR_W'(pos_err_pkg::ERR_RESET);
            st_r.num <= pos_err_pkg::NUM_RESET;
            st_r.den <= pos_err_pkg::DEN_RESET;
            st_r.rem <= pos_err_pkg::REM_RESET;
            st_r.mode <= pos_err_pkg::MODE_CLR_SOFF;
            st_r.width <= 1'b0;
            st_r.filt <= 1'b0;
            st_r.ack <= 1'b0;
            st_r.rdat <= 32'h0;
            st_r.loopEn <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ack_o = st_r.ack;
    assign dat_o = st_r.rdat;
    assign posError = st_r.err;
    assign loopEnable = st_r.loopEn;
    assign inputNoiseFilterSel = st_r.filt;
endmodule

// ---- inc/pos_err_pkg.sv ----
package pos_err_pkg;
    // ********************
    // widths and encodings
    // ********************
    localparam int ERR_W = 32;
    localparam int GEAR_W = 16;
    localparam int MODE_W = 2;
    localparam logic [1:0] MODE_CLR_SOFF = 2'h0;
    localparam logic [1:0] MODE_NO_CLR = 2'h1;
    localparam logic [1:0] MODE_CLR_SOFF_OT = 2'h2;
    localparam logic [31:0] ERR_RESET = 32'h0000_0000;
    localparam logic [15:0] NUM_RESET = 16'h0001;
    localparam logic [15:0] DEN_RESET = 16'h0001;
    localparam logic [15:0] REM_RESET = 16'h0000;
    // ******************
    // register map (bytes)
    // ******************
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_NUM = 4'h4;
    localparam logic [3:0] OFS_DEN = 4'h8;
    localparam logic [3:0] OFS_ERR = 4'hc;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_WIDTH_BIT = 2;
    localparam int CTRL_FILT_BIT = 3;
    localparam int CTRL_SON_BIT = 4;
    localparam int CTRL_CLR_BIT = 5;
endpackage

// ---- tb/pos_err_checker.sv ----
`timescale 1ns/1ns
module pos_err_checker #(
    parameter int ERR_W = pos_err_pkg::ERR_W
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // register bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic [31:0] dat_o,
    // reference and feedback pulses
    input wire logic refPulse,
    input wire logic refDir,
    input wire logic fbPulse,
    input wire logic fbDir,
    // drive status and loop
    input wire logic errorClearN,
    input wire logic servoOn,
    input wire logic overtravel,
    input wire logic loopEnable,
    input wire logic [ERR_W-1:0] posError
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    chk_clear_zero: assert property (!errorClearN |=> posError == '0)
        else $error("counter not zero under clear");
    chk_loop_off: assert property (!errorClearN |=> !loopEnable)
        else $error("loop enabled under clear");
    chk_loop_on: assert property (errorClearN && servoOn |=> loopEnable)
        else $error("loop not enabled");
    chk_count_hold: assert property (
        errorClearN && servoOn && !overtravel && !refPulse && !fbPulse
        |=> $stable(posError))
        else $error("counter moved without pulses");
    chk_gear_step: assert property (
        errorClearN && servoOn && !overtravel && refPulse && refDir && !fbPulse
        |=> posError - $past(posError) <= 2)
        else $error("forward step out of range");
    chk_fb_sub: assert property (
        errorClearN && servoOn && !overtravel && fbPulse && fbDir && !refPulse
        |=> posError == $past(posError) - 1)
        else $error("feedback count not subtracted");
    chk_ack_one: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    chk_ack_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered");
    chk_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data outside ack");
endmodule
bind position_error_clear_gear pos_err_checker #(
    .ERR_W(ERR_W)
) chk_u (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .ack_o(ack_o),
    .dat_o(dat_o),
    .refPulse(refPulse),
    .refDir(refDir),
    .fbPulse(fbPulse),
    .fbDir(fbDir),
    .errorClearN(errorClearN),
    .servoOn(servoOn),
    .overtravel(overtravel),
    .loopEnable(loopEnable),
    .posError(posError)
);

// ---- tb/host_pulse_model.sv ----
`timescale 1ns/1ns
module host_pulse_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // control from bench
    input wire logic load,
    input wire logic dir,
    input wire logic [3:0] count,
    // reference pulses
    output logic refPulse,
    output logic refDir
);
    logic [3:0] left;
    // back-to-back pulses, one reference unit per high cycle
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            left <= 4'h0;
            refPulse <= 1'b0;
            refDir <= 1'b0;
        end else begin
            left <= load ? count : (left != 4'h0 ? left - 4'h1 : 4'h0);
            refPulse <= !load && left != 4'h0;
            refDir <= dir;
        end
    end
endmodule

// ---- tb/position_error_clear_gear_bench.sv ----
`timescale 1ns/1ns
module position_error_clear_gear_bench;
    logic ref_clk = 1'b0, nrst = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, load = 1'b0;
    logic fbPulse = 1'b0, fbDir = 1'b1, errorClearN = 1'b1, servoOn = 1'b1, overtravel = 1'b0;
    logic zeroClampStop = 1'b0, dir = 1'b1, ack_o, refPulse, refDir, loopEnable;
    logic inputNoiseFilterSel;
    logic [3:0] adr_i = 4'h0, count = 4'h0, sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0, dat_o, q, posError;
    int err_count = 0, check_count = 0;
    always #50 ref_clk = ~ref_clk;
    host_pulse_model host_u (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .load(load),
        .dir(dir),
        .count(count),
        .refPulse(refPulse),
        .refDir(refDir)
    );
    position_error_clear_gear dut_u (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .cyc_i(cyc_i),
        .stb_i(stb_i),
        .we_i(we_i),
        .adr_i(adr_i),
        .sel_i(sel_i),
        .dat_i(dat_i),
        .dat_o(dat_o),
        .ack_o(ack_o),
        .refPulse(refPulse),
        .refDir(refDir),
        .fbPulse(fbPulse),
        .fbDir(fbDir),
        .errorClearN(errorClearN),
        .servoOn(servoOn),
        .overtravel(overtravel),
        .zeroClampStop(zeroClampStop),
        .loopEnable(loopEnable),
        .posError(posError),
        .inputNoiseFilterSel(inputNoiseFilterSel)
    );
    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, d};
        // ack and read data are taken at the very rising edge that finds ack high
        do @(posedge ref_clk); while (ack_o !== 1'b1);
        q = dat_o;
        {cyc_i, stb_i} <= 2'h0;
    endtask
    task pulses(input logic [3:0] n, input logic d);
        @(posedge ref_clk);
        {load, count, dir} <= {1'b1, n, d};
        @(posedge ref_clk);
        load <= 1'b0;
        repeat (20) @(posedge ref_clk);
    endtask
    task clear_pin;
        @(posedge ref_clk);
        errorClearN <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check(posError, 32'h0);
        check({31'h0, loopEnable}, 32'h0);
        errorClearN <= 1'b1;
        @(posedge ref_clk);
    endtask
    task regs_test;
        wb(0, pos_err_pkg::OFS_NUM, 0);
        check(q, 32'h1);
        wb(1, pos_err_pkg::OFS_DEN, 0);
        wb(0, pos_err_pkg::OFS_DEN, 0);
        check(q, 32'h1);
        wb(1, pos_err_pkg::OFS_CTRL, 32'h8);
        wb(0, pos_err_pkg::OFS_CTRL, 0);
        check(q, 32'h18);
        check({31'h0, inputNoiseFilterSel}, 32'h1);
        $display("register test done");
    endtask
    task gear_test;
        clear_pin;
        wb(1, pos_err_pkg::OFS_CTRL, 32'h1);
        pulses(4'h5, 1'b1);
        check(posError, 32'h5);
        wb(1, pos_err_pkg::OFS_NUM, 32'h2);
        wb(1, pos_err_pkg::OFS_CTRL, 32'h5);
        pulses(4'h3, 1'b1);
        check(posError, 32'hb);
        @(posedge ref_clk);
        fbPulse <= 1'b1;
        repeat (2) @(posedge ref_clk);
        fbPulse <= 1'b0;
        wb(0, pos_err_pkg::OFS_ERR, 0);
        check(q, 32'h9);
        pulses(4'h3, 1'b0);
        check(posError, 32'h3);
        $display("gear test done");
    endtask
    task mode_case(input logic [1:0] m, input logic s, o, z, cl);
        clear_pin;
        wb(1, pos_err_pkg::OFS_CTRL, {30'h0, m});
        pulses(4'h3, 1'b1);
        {servoOn, overtravel, zeroClampStop} <= {s, o, z};
        repeat (3) @(posedge ref_clk);
        check(posError, cl ? 32'h0 : 32'h3);
        // pulses that arrive while the drive is off or stopped keep piling up where the mode does not clear
        pulses(4'h3, 1'b1);
        check(posError, cl ? 32'h0 : 32'h6);
        {servoOn, overtravel, zeroClampStop} <= 3'h4;
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        give_verdict;
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        regs_test;
        gear_test;
        mode_case(2'h0, 0, 0, 0, 1);
        mode_case(2'h0, 1, 1, 0, 0);
        mode_case(2'h1, 0, 1, 0, 0);
        mode_case(2'h2, 0, 0, 0, 1);
        mode_case(2'h2, 1, 1, 0, 1);
        mode_case(2'h2, 1, 1, 1, 0);
        // the spare mode code must not clear on its own
        mode_case(2'h3, 0, 1, 0, 0);
        $display("clear mode test done");
        give_verdict;
    end
endmodule
